// [design/sfr_seq.sv]
// flash command sequencer: resume handling and single, dual, quad output reads
`include "sfr_defines.svh"
`timescale 1ns/10ps
module sfr_seq #(
  parameter int MEM_AW = 10
) (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic sck_in,
  input wire logic cs_n_in,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe_out,
  input wire logic four_wire_command_mode_in,
  input wire logic addr4_mode_in,
  input wire logic quad_lines_enable_flag_in,
  input wire logic param_wr_in,
  input wire logic [1:0] param_in,
  input wire logic op_start_in,
  input wire logic op_done_in,
  input wire logic suspend_req_in,
  input wire logic mem_wr_en_in,
  input wire logic [MEM_AW-1:0] mem_wr_addr_in,
  input wire logic [7:0] mem_wr_data_in,
  output logic busy_out,
  output logic suspend_status_flag_out,
  output logic resume_out
);
  localparam logic [4:0] DLY_LOAD =
    5'(`SFR_RESUME_CYC - `SFR_SYNC_CYC - 2);

  // ---------------------------------------------------------------
  // flash array
  // ---------------------------------------------------------------
  // written on the core clock, read on the link clock; loading while a
  // read frame runs gives undefined bytes
  logic [7:0] mem [0:(1<<MEM_AW)-1];

  always_ff @(posedge core_clk_in) begin
    if (mem_wr_en_in) begin
      mem[mem_wr_addr_in] <= mem_wr_data_in;
    end
  end

  // ---------------------------------------------------------------
  // core domain: status flags and resume timing
  // ---------------------------------------------------------------
  typedef struct packed {
    logic busy;
    logic susp;
    logic [1:0] param;
    logic dly_on;
    logic [4:0] dly;
    logic [2:0] tsync;
    logic resume;
  } sfr_core_t;

  sfr_core_t cq;
  sfr_core_t cd;
  logic res_tog_q;
  logic res_ev;
  logic res_acc;

  always_comb begin
    cd = cq;
    cd.resume = 1'b0;
    cd.tsync = {cq.tsync[1:0], res_tog_q};
    res_ev = cq.tsync[2] ^ cq.tsync[1];
    res_acc = res_ev && cq.susp && !cq.busy;
    if (op_done_in) begin
      cd.busy = 1'b0;
    end
    if (op_start_in) begin
      cd.busy = 1'b1;
    end
    if (suspend_req_in && !cq.susp && cq.busy) begin
      cd.susp = 1'b1;
      cd.busy = 1'b0;
    end
    if (res_acc) begin
      cd.susp = 1'b0;
      cd.dly_on = 1'b1;
      cd.dly = DLY_LOAD;
    end else if (cq.dly_on) begin
      if (cq.dly == '0) begin
        cd.dly_on = 1'b0;
        cd.busy = 1'b1;
        cd.resume = 1'b1;
      end else begin
        cd.dly = cq.dly - 5'h01;
      end
    end
    if (param_wr_in) begin
      cd.param = param_in;
    end
    if (!rstn_in) begin
      cd = '0;
      cd.param = `SFR_PARAM_RST;
    end
  end

  always_ff @(posedge core_clk_in) begin
    cq <= cd;
  end

  assign busy_out = cq.busy;
  assign suspend_status_flag_out = cq.susp;
  assign resume_out = cq.resume;

  AST_RESUME_GUARD: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    $fell(cq.susp) |-> $past(!cq.busy))
    else $error("suspend flag cleared while busy");
  AST_RESUME_CLEARS: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    res_acc |=> !cq.susp)
    else $error("accepted resume left suspend flag set");
  AST_RESUME_BUSY: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    res_acc && !op_done_in |-> ##21 cq.busy && cq.resume)
    else $error("busy not raised in time after resume");
  AST_RESUME_IGNORED: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    res_ev && !res_acc && !suspend_req_in |=> cq.susp == $past(cq.susp) &&
    (!cq.dly_on || $past(cq.dly_on)))
    else $error("refused resume changed state");
  AST_SUSPEND_SETS: assert property (@(posedge core_clk_in) disable iff (!rstn_in)
    suspend_req_in && !cq.susp && cq.busy |=> cq.susp && !cq.busy)
    else $error("accepted suspend did not set suspend flag");

  // ---------------------------------------------------------------
  // link domain: synchronisers and resume toggle
  // ---------------------------------------------------------------
  logic [5:0] cfg_raw;
  logic [5:0] cfg_s1;
  logic [5:0] cfg_s2;
  logic res_fire;
  logic fw_mode;
  logic a4;
  logic quad_ok;
  logic busy_l;
  logic [1:0] prm;

  assign cfg_raw = {cq.param, cq.busy, quad_lines_enable_flag_in, addr4_mode_in,
                    four_wire_command_mode_in};
  assign fw_mode = cfg_s2[0];
  assign a4 = cfg_s2[1];
  assign quad_ok = cfg_s2[2];
  assign busy_l = cfg_s2[3];
  assign prm = cfg_s2[5:4];

  // these must survive deselect, so only the power-on reset clears them
  always_ff @(posedge sck_in or negedge rstn_in) begin
    if (!rstn_in) begin
      res_tog_q <= 1'b0;
      cfg_s1 <= '0;
      cfg_s2 <= '0;
    end else begin
      res_tog_q <= res_tog_q ^ res_fire;
      cfg_s1 <= cfg_raw;
      cfg_s2 <= cfg_s1;
    end
  end

  // ---------------------------------------------------------------
  // link domain: command, address, dummy and data phases
  // ---------------------------------------------------------------
  typedef struct packed {
    sfr_pkg::sfr_lstate_t st;
    logic [5:0] cnt;
    logic [5:0] alast;
    logic [3:0] dnum;
    logic [2:0] lanes;
    logic [7:0] op;
    logic [31:0] addr;
    logic [31:0] rd;
    logic [7:0] sr;
    logic [3:0] nb;
  } sfr_link_t;

  sfr_link_t lq;
  sfr_link_t ld;
  logic serial_in_line;
  logic [7:0] op_full;
  logic [31:0] a_full;
  logic [5:0] clast;
  logic dec_ok;
  logic use4;
  logic [3:0] dq;
  logic [2:0] ln;
  logic [3:0] pdum;
  logic start;
  logic [31:0] start_a;
  logic f_push;
  logic f_rdy;
  logic f_val;
  logic f_pop;
  logic [7:0] f_dat;

  assign serial_in_line = io_in[0];

  always_comb begin
    op_full = fw_mode ? {lq.op[3:0], io_in} : {lq.op[6:0], serial_in_line};
    a_full = fw_mode ? {lq.addr[27:0], io_in} : {lq.addr[30:0], serial_in_line};
    clast = fw_mode ? `SFR_CLAST_FW : `SFR_CLAST_STD;
    case (prm)
      2'h0: pdum = `SFR_DUMMY_P0;
      2'h1: pdum = `SFR_DUMMY_P1;
      default: pdum = `SFR_DUMMY_P2;
    endcase
    dec_ok = 1'b0;
    use4 = a4;
    dq = '0;
    ln = 3'h1;
    case (op_full)
      `SFR_OP_READ: begin
        dec_ok = !fw_mode;
      end
      `SFR_OP_READ4: begin
        dec_ok = !fw_mode;
        use4 = 1'b1;
      end
      `SFR_OP_FAST: begin
        dec_ok = 1'b1;
        dq = fw_mode ? pdum : `SFR_DUMMY_STD;
        ln = fw_mode ? 3'h4 : 3'h1;
      end
      `SFR_OP_FAST4: begin
        dec_ok = !fw_mode;
        use4 = 1'b1;
        dq = `SFR_DUMMY_STD;
      end
      `SFR_OP_DUAL: begin
        dec_ok = !fw_mode;
        dq = `SFR_DUMMY_STD;
        ln = 3'h2;
      end
      `SFR_OP_DUAL4: begin
        dec_ok = !fw_mode;
        use4 = 1'b1;
        dq = `SFR_DUMMY_STD;
        ln = 3'h2;
      end
      `SFR_OP_QUAD: begin
        dec_ok = !fw_mode && quad_ok;
        dq = `SFR_DUMMY_STD;
        ln = 3'h4;
      end
      default: begin
        dec_ok = 1'b0;
      end
    endcase
    res_fire = (lq.st == sfr_pkg::ST_CMD) && (lq.cnt == clast) &&
               (op_full == `SFR_OP_RESUME);
    f_push = (lq.st == sfr_pkg::ST_DATA);
    f_pop = (lq.st == sfr_pkg::ST_DATA) && (lq.nb == 4'(lq.lanes));
    start = 1'b0;
    start_a = lq.addr;
    ld = lq;
    ld.cnt = lq.cnt + 6'h01;
    case (lq.st)
      sfr_pkg::ST_CMD: begin
        ld.op = op_full;
        if (lq.cnt == clast) begin
          ld.cnt = '0;
          ld.dnum = dq;
          ld.lanes = ln;
          if (fw_mode) begin
            ld.alast = use4 ? `SFR_ALAST_FW4 : `SFR_ALAST_FW3;
          end else begin
            ld.alast = use4 ? `SFR_ALAST_STD4 : `SFR_ALAST_STD3;
          end
          // a read seen while busy is dropped; the running cycle is untouched
          ld.st = (dec_ok && !busy_l) ? sfr_pkg::ST_ADDR : sfr_pkg::ST_IGNORE;
        end
      end
      sfr_pkg::ST_ADDR: begin
        ld.addr = a_full;
        if (lq.cnt == lq.alast) begin
          ld.cnt = '0;
          if (lq.dnum == '0) begin
            start = 1'b1;
            start_a = a_full;
          end else begin
            ld.st = sfr_pkg::ST_DUMMY;
          end
        end
      end
      sfr_pkg::ST_DUMMY: begin
        // line values here are don't care
        if (lq.cnt == 6'(lq.dnum - 4'h1)) begin
          start = 1'b1;
        end
      end
      sfr_pkg::ST_DATA: begin
        ld.sr = lq.sr << lq.lanes;
        ld.nb = lq.nb - 4'(lq.lanes);
        if (f_pop) begin
          ld.sr = f_dat;
          ld.nb = 4'h8;
        end
        if (f_rdy) begin
          ld.rd = lq.rd + 32'h1;
        end
      end
      sfr_pkg::ST_IGNORE: begin
        ld.cnt = lq.cnt;
      end
      default: begin
        ld.st = sfr_pkg::ST_IGNORE;
      end
    endcase
    if (start) begin
      ld.st = sfr_pkg::ST_DATA;
      ld.sr = mem[start_a[MEM_AW-1:0]];
      ld.nb = 4'h8;
      ld.rd = start_a + 32'h1;
    end
  end

  // raising chip select ends any frame
  always_ff @(posedge sck_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      lq <= '0;
    end else begin
      lq <= ld;
    end
  end

  // two bytes of prefetch keep quad output fed: one byte lasts two clocks
  sfr_buf2 #(
    .WIDTH(8),
    .DEPTH(2)
  ) u_buf (
    .clk_in(sck_in),
    .clr_in(cs_n_in),
    .in_valid_in(f_push),
    .in_ready_out(f_rdy),
    .in_data_in(mem[lq.rd[MEM_AW-1:0]]),
    .out_valid_out(f_val),
    .out_ready_in(f_pop),
    .out_data_out(f_dat)
  );

  // ---------------------------------------------------------------
  // link domain: falling-edge output stage
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [3:0] oe;
    logic [3:0] o;
  } sfr_out_t;

  sfr_out_t oq;
  sfr_out_t od;

  always_comb begin
    od = '0;
    if (lq.st == sfr_pkg::ST_DATA) begin
      case (lq.lanes)
        3'h4: begin
          od.oe = 4'hf;
          od.o = lq.sr[7:4];
        end
        3'h2: begin
          od.oe = 4'h3;
          od.o = {2'h0, lq.sr[7:6]};
        end
        default: begin
          od.oe = 4'h2;
          od.o = {2'h0, lq.sr[7], 1'b0};
        end
      endcase
    end
  end

  always_ff @(negedge sck_in or posedge cs_n_in) begin
    if (cs_n_in) begin
      oq <= '0;
    end else begin
      oq <= od;
    end
  end

  assign io_out = oq.o;
  assign io_oe_out = oq.oe;

  AST_READ_BUSY_DROP: assert property (@(posedge sck_in) disable iff (cs_n_in)
    lq.st == sfr_pkg::ST_CMD && lq.cnt == clast && busy_l |=> lq.st == sfr_pkg::ST_IGNORE)
    else $error("read accepted while busy");
  AST_ADDR_ADVANCE: assert property (@(posedge sck_in) disable iff (cs_n_in)
    f_push && f_rdy |=> lq.rd == $past(lq.rd) + 32'h1)
    else $error("read address did not advance");
  AST_OP13_LEN: assert property (@(posedge sck_in) disable iff (cs_n_in)
    lq.st == sfr_pkg::ST_CMD && lq.cnt == clast && !fw_mode && !busy_l &&
    op_full == `SFR_OP_READ4 |=> lq.alast == `SFR_ALAST_STD4 && lq.dnum == '0)
    else $error("13h address length wrong");
  AST_FAST_DUMMY: assert property (@(posedge sck_in) disable iff (cs_n_in)
    lq.st == sfr_pkg::ST_CMD && lq.cnt == clast && !fw_mode &&
    op_full == `SFR_OP_FAST |=> lq.dnum == `SFR_DUMMY_STD && lq.lanes == 3'h1)
    else $error("fast read dummy count wrong");
  AST_QUAD_GATE: assert property (@(posedge sck_in) disable iff (cs_n_in)
    lq.st == sfr_pkg::ST_CMD && lq.cnt == clast && !quad_ok &&
    op_full == `SFR_OP_QUAD |=> lq.st == sfr_pkg::ST_IGNORE)
    else $error("quad read taken without quad enable");
  AST_BYTE_FED: assert property (@(posedge sck_in) disable iff (cs_n_in)
    f_pop |-> f_val)
    else $error("output byte needed but buffer empty");
endmodule

// [shared/sfr_defines.svh]
// opcodes, timing counts and reset values of the flash read and resume sequencer
`ifndef SFR_DEFINES_SVH
`define SFR_DEFINES_SVH
`define SFR_OP_RESUME 8'h7a
`define SFR_OP_READ 8'h03
`define SFR_OP_READ4 8'h13
`define SFR_OP_FAST 8'h0b
`define SFR_OP_FAST4 8'h0c
`define SFR_OP_DUAL 8'h3b
`define SFR_OP_DUAL4 8'h3c
`define SFR_OP_QUAD 8'h6b
`define SFR_CORE_MHZ 125
`define SFR_RESUME_NS 200
// longest time, so the cycle count rounds down
`define SFR_RESUME_CYC ((`SFR_RESUME_NS * `SFR_CORE_MHZ) / 1000)
// worst toggle-sync plus edge-detect latency, taken out of the budget
`define SFR_SYNC_CYC 4
`define SFR_DUMMY_STD 4'h8
`define SFR_DUMMY_P0 4'h4
`define SFR_DUMMY_P1 4'h6
`define SFR_DUMMY_P2 4'h8
`define SFR_PARAM_RST 2'h0
`define SFR_CLAST_STD 6'h07
`define SFR_CLAST_FW 6'h01
`define SFR_ALAST_STD3 6'h17
`define SFR_ALAST_STD4 6'h1f
`define SFR_ALAST_FW3 6'h05
`define SFR_ALAST_FW4 6'h07
`endif

// [shared/sfr_pkg.sv]
// types of the flash read and resume sequencer
package sfr_pkg;
  typedef enum logic [2:0] {ST_CMD, ST_ADDR, ST_DUMMY, ST_DATA, ST_IGNORE} sfr_lstate_t;
endpackage

// [design/sfr_buf2.sv]
// small buffer between the array read port and the output shifter
`timescale 1ns/10ps
module sfr_buf2 #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk_in,
  input wire logic clr_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [PW:0] FULL = (PW+1)'(DEPTH);
  localparam logic [PW-1:0] LASTP = PW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
  } sfr_buf_t;

  sfr_buf_t q;
  sfr_buf_t d;
  logic push;
  logic pop;

  always_comb begin
    in_ready_out = (q.cnt != FULL);
    out_valid_out = (q.cnt != '0);
    out_data_out = q.mem[q.rp];
    push = in_valid_in && in_ready_out;
    pop = out_valid_out && out_ready_in;
    d = q;
    if (push) begin
      d.mem[q.wp] = in_data_in;
      d.wp = (q.wp == LASTP) ? '0 : q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = (q.rp == LASTP) ? '0 : q.rp + 1'b1;
    end
    d.cnt = q.cnt + (PW+1)'(push) - (PW+1)'(pop);
  end

  // deselect empties the buffer: a new frame never sees stale bytes
  always_ff @(posedge clk_in or posedge clr_in) begin
    if (clr_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

// [testbench/sfr_host.sv]
// host side model: spi mode 0 controller that frames commands and collects read data
`timescale 1ns/10ps
module sfr_host (
  input wire logic [3:0] io_out_in,
  input wire logic [3:0] io_oe_in,
  output logic sck_out,
  output logic cs_n_out,
  output logic [3:0] io_in_out
);
  logic [3:0] drv_q;
  logic [3:0] en_q;
  logic [3:0] junk_q;
  logic [7:0] rd [0:7];
  logic [3:0] oe_seen;
  realtime op_end;
  // ----------------------------------------
  // wire levels
  // ----------------------------------------
  // released lines toggle so a stale value never looks valid
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      io_in_out[i] = io_oe_in[i] ? io_out_in[i] : (en_q[i] ? drv_q[i] : junk_q[i]);
    end
  end
  initial begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    drv_q = 4'h0;
    en_q = 4'h0;
    junk_q = 4'h5;
  end
  // ----------------------------------------
  // frame tasks
  // ----------------------------------------
  task automatic pulse();
    #3 sck_out = 1'b1;
    junk_q = ~junk_q;
    #3 sck_out = 1'b0;
  endtask
  task automatic idle(input int n);
    repeat (n) pulse();
  endtask
  task automatic send(input logic [31:0] v, input int nbits, input int w);
    for (int i = nbits - w; i >= 0; i -= w) begin
      en_q = (w == 4) ? 4'hf : 4'h1;
      drv_q = (w == 4) ? v[i +: 4] : {3'h0, v[i]};
      pulse();
    end
  endtask
  task automatic frame(input logic [7:0] op, input logic [31:0] addr, input int abits,
                       input int dum, input int w, input int lanes, input int nbytes);
    #1.3 cs_n_out = 1'b0;
    send({24'h0, op}, 8, w);
    op_end = $realtime - 3.0;
    send(addr, abits, w);
    en_q = 4'h0;
    repeat (dum) pulse();
    oe_seen = 4'h0;
    for (int b = 0; b < nbytes; b++) begin
      for (int k = 0; k < 8 / lanes; k++) begin
        #3 sck_out = 1'b1;
        oe_seen = oe_seen | io_oe_in;
        rd[b] = (lanes == 4) ? {rd[b][3:0], io_in_out} :
                (lanes == 2) ? {rd[b][5:0], io_in_out[1:0]} : {rd[b][6:0], io_in_out[1]};
        junk_q = ~junk_q;
        #3 sck_out = 1'b0;
      end
    end
    #3 cs_n_out = 1'b1;
    #6;
  endtask
endmodule

// [testbench/tb.sv]
// self-checking bench of the flash read and resume sequencer
`timescale 1ns/10ps
module tb;
  typedef struct {
    logic [7:0] op;
    logic a4, fw, quad_en, pw;
    logic [1:0] par;
    int abits, dum, lanes;
    logic [3:0] oe;
  } sfr_row_t;
  logic core_clk, rstn_in, sck, cs_n, four_wire, a4, quad_en, param_wr, op_start, op_done;
  logic susp_req, mem_wr_en, busy, susp_flag, resume;
  logic [1:0] param;
  logic [3:0] io_in, io_out, io_oe;
  logic [9:0] mem_wr_addr;
  logic [7:0] mem_wr_data;
  logic [31:0] addr;
  int errors = 0;
  int check_count = 0;
  int resumes = 0;
  int cycles = 0;
  sfr_row_t rows [15] = '{
    '{8'h03, 0, 0, 0, 0, 0, 24, 0, 1, 4'h2},
    '{8'h03, 1, 0, 0, 0, 0, 32, 0, 1, 4'h2},
    '{8'h13, 0, 0, 0, 0, 0, 32, 0, 1, 4'h2},
    '{8'h0b, 0, 0, 0, 0, 0, 24, 8, 1, 4'h2},
    '{8'h0c, 0, 0, 0, 0, 0, 32, 8, 1, 4'h2},
    '{8'h3b, 0, 0, 0, 0, 0, 24, 8, 2, 4'h3},
    '{8'h3c, 1, 0, 0, 0, 0, 32, 8, 2, 4'h3},
    '{8'h6b, 0, 0, 1, 0, 0, 24, 8, 4, 4'hf},
    '{8'h6b, 0, 0, 0, 0, 0, 24, 8, 4, 4'h0},
    '{8'h0b, 0, 1, 0, 0, 0, 24, 4, 4, 4'hf},
    '{8'h0b, 1, 1, 0, 1, 1, 32, 6, 4, 4'hf},
    '{8'h0b, 0, 1, 0, 1, 2, 24, 8, 4, 4'hf},
    '{8'h0b, 0, 1, 0, 1, 3, 24, 8, 4, 4'hf},
    '{8'h13, 0, 1, 0, 0, 0, 32, 0, 4, 4'h0},
    '{8'h0c, 0, 1, 0, 0, 0, 32, 8, 4, 4'h0}
  };
  // ----------------------------------------
  // design and far side
  // ----------------------------------------
  sfr_seq #(.MEM_AW(10)) i_sfr_seq (.core_clk_in(core_clk), .rstn_in(rstn_in), .sck_in(sck),
    .cs_n_in(cs_n), .io_in(io_in), .io_out(io_out), .io_oe_out(io_oe),
    .four_wire_command_mode_in(four_wire), .addr4_mode_in(a4),
    .quad_lines_enable_flag_in(quad_en), .param_wr_in(param_wr), .param_in(param),
    .op_start_in(op_start), .op_done_in(op_done), .suspend_req_in(susp_req),
    .mem_wr_en_in(mem_wr_en), .mem_wr_addr_in(mem_wr_addr), .mem_wr_data_in(mem_wr_data),
    .busy_out(busy), .suspend_status_flag_out(susp_flag), .resume_out(resume));
  sfr_host i_sfr_host (.io_out_in(io_out), .io_oe_in(io_oe), .sck_out(sck), .cs_n_out(cs_n),
    .io_in_out(io_in));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // hang guard, far above the few thousand cycles the run needs
  // sampled mid-cycle: the resume pulse is settled there
  always @(negedge core_clk) begin
    cycles++;
    if (resume === 1'b1) resumes++;
    if (cycles == 20000) begin
      errors++;
      conclude();
    end
  end
  function automatic logic [7:0] pat(input logic [31:0] a);
    pat = a[7:0] ^ {a[9:8], 6'h2d};
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: %s seen %0h expected %0h", $time, msg, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic flags(input logic b, input logic s, input int r);
    check(8'(busy), 8'(b), "busy");
    check(8'(susp_flag), 8'(s), "suspend flag");
    check(8'(resumes), 8'(r), "resume count");
  endtask
  task automatic resume_frame();
    i_sfr_host.idle(3);
    i_sfr_host.frame(8'h7a, 32'h0, 0, 0, 1, 1, 0);
    repeat (40) @(negedge core_clk);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {rstn_in, four_wire, a4, quad_en, param_wr, op_start, op_done, susp_req, mem_wr_en} = '0;
    {param, mem_wr_addr, mem_wr_data} = '0;
    repeat (10) @(negedge core_clk);
    flags(1'b0, 1'b0, 0);
    check(8'(io_oe), 8'h00, "enables in reset");
    rstn_in = 1'b1;
    for (int a = 0; a < 1024; a++) begin
      mem_wr_en = 1'b1;
      mem_wr_addr = 10'(a);
      mem_wr_data = pat(32'(a));
      @(negedge core_clk);
    end
    mem_wr_en = 1'b0;
    for (int r = 0; r < 15; r++) begin
      addr = (32'h0000_03fc + 32'(r)) & 32'h0000_03ff;
      {four_wire, a4, quad_en, param_wr, param} = {rows[r].fw, rows[r].a4, rows[r].quad_en,
                                                   rows[r].pw,
                                              rows[r].par};
      @(negedge core_clk);
      param_wr = 1'b0;
      repeat (2) @(negedge core_clk);
      i_sfr_host.idle(3);
      i_sfr_host.frame(rows[r].op, addr, rows[r].abits, rows[r].dum, rows[r].fw ? 4 : 1,
                       rows[r].lanes, 3);
      check(8'(i_sfr_host.oe_seen), 8'(rows[r].oe), "drive enables");
      for (int k = 0; k < 3; k++) begin
        if (rows[r].oe !== 4'h0) check(i_sfr_host.rd[k], pat(addr + 32'(k)), "byte");
      end
    end
    four_wire = 1'b0;
    resume_frame();
    flags(1'b0, 1'b0, 0);
    op_start = 1'b1;
    @(negedge core_clk);
    op_start = 1'b0;
    i_sfr_host.idle(3);
    i_sfr_host.frame(8'h03, 32'h10, 24, 0, 1, 1, 2);
    check(8'(i_sfr_host.oe_seen), 8'h00, "read while busy");
    resume_frame();
    flags(1'b1, 1'b0, 0);
    susp_req = 1'b1;
    @(negedge core_clk);
    susp_req = 1'b0;
    @(negedge core_clk);
    flags(1'b0, 1'b1, 0);
    op_start = 1'b1;
    @(negedge core_clk);
    op_start = 1'b0;
    resume_frame();
    flags(1'b1, 1'b1, 0);
    op_done = 1'b1;
    @(negedge core_clk);
    op_done = 1'b0;
    i_sfr_host.idle(3);
    i_sfr_host.frame(8'h7a, 32'h0, 0, 0, 1, 1, 0);
    for (int n = 0; n < 40 && busy !== 1'b1; n++) begin
      @(posedge core_clk);
      #0.1;
    end
    check(8'(($realtime - 0.1 - i_sfr_host.op_end) <= 200.0), 8'h01, "busy delay");
    check(8'(resume), 8'h01, "resume pulse");
    check(8'(susp_flag), 8'h00, "suspend cleared");
    repeat (50) @(negedge core_clk);
    flags(1'b1, 1'b0, 1);
    // minimum interval kept before the next suspend
    susp_req = 1'b1;
    @(negedge core_clk);
    susp_req = 1'b0;
    @(negedge core_clk);
    flags(1'b0, 1'b1, 1);
    conclude();
  end
endmodule
